//--- psl_board_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Board side of the strap pins: weak pulls, resistors, MAC
// ------------------------------------------------------------
module psl_board_model (
  input  wire logic [8:0]               pin_out,
  input  wire logic [8:0]               pin_oe_n,
  input  wire logic [8:0]               ext_en,
  input  wire logic [8:0]               ext_val,
  output psl_strap_pkg::psl_pins_t      pin_in
);
  // Weak pull level of each pin, in pin struct order
  localparam logic [8:0] PULL_LVL = 9'h046;

  // Device drives when enabled; else board resistor, else pull
  // The MAC never drives the receive lines while pins are inputs
  assign pin_in = (~pin_oe_n & pin_out)
                | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & PULL_LVL);
endmodule

//--- psl_strap_latch.sv
`timescale 1ns/100ps
module psl_strap_latch (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     chip_reset_n,
  input  wire psl_strap_pkg::psl_pins_t pin_in,
  input  wire psl_strap_pkg::psl_pins_t fn_out,
  output logic [8:0]                    pin_out,
  output logic [8:0]                    pin_oe_n,
  input  wire logic [4:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [15:0]                   reg_rdata,
  output logic [4:0]                    mgmt_addr,
  output logic [2:0]                    mode_code,
  output logic                          mode_b2b,
  output logic                          mode_xover_en,
  output logic                          mode_reserved,
  output logic                          disable_strap_a_en,
  output logic                          nand_tree_en,
  output logic                          line_filter_en
);

  // ------------------------------------------------------------
  // State and storage
  // ------------------------------------------------------------
  psl_strap_pkg::psl_state_t state_ff;
  psl_strap_pkg::psl_state_t nxt_state;
  psl_strap_pkg::psl_cfg_t   cfg_ff;
  psl_strap_pkg::psl_cfg_t   nxt_cfg;
  logic                      an_ctrl_ff;
  logic                      nxt_an_ctrl;
  logic [8:0]                pin_out_ff;
  logic [8:0]                pin_oe_n_ff;
  logic [15:0]               rdata_ff;
  logic [15:0]               nxt_rdata;
  logic                      capture;
  logic                      ctrl_wr;
  logic [15:0]               ctrl_word;
  logic [15:0]               strap_word;

  // Decode of a mode code into crossover enable
  function automatic logic mode_xover(input logic [2:0] code);
    mode_xover = (code == psl_strap_pkg::PSL_MODE_B2B) ||
                 (code == psl_strap_pkg::PSL_MODE_NRMX);
  endfunction

  // Decode of a mode code into reserved flag
  function automatic logic mode_rsvd(input logic [2:0] code);
    mode_rsvd = !mode_xover(code) && (code != psl_strap_pkg::PSL_MODE_NRM);
  endfunction

  // ------------------------------------------------------------
  // Reset tracking and strap capture
  // ------------------------------------------------------------
  // Capture happens on the first cycle chip reset is seen high
  // Gated by rst so that the last reset edge is never taken for a capture
  assign capture = !rst && chip_reset_n &&
                   (state_ff == psl_strap_pkg::PSL_ST_RESET);

  // Next state follows the chip reset pin
  always_comb begin
    case (state_ff)
      psl_strap_pkg::PSL_ST_RESET: begin
        nxt_state = chip_reset_n ? psl_strap_pkg::PSL_ST_RUN : psl_strap_pkg::PSL_ST_RESET;
      end
      psl_strap_pkg::PSL_ST_RUN: begin
        nxt_state = chip_reset_n ? psl_strap_pkg::PSL_ST_RUN : psl_strap_pkg::PSL_ST_RESET;
      end
      default: begin
        nxt_state = psl_strap_pkg::PSL_ST_RESET;
      end
    endcase
  end

  // Configuration loads only at release and is held otherwise
  always_comb begin
    nxt_cfg = cfg_ff;
    if (capture) begin
      nxt_cfg.addr     = {pin_in.mgmt_addr_strap_bit2, pin_in.mgmt_addr_strap_bit1,
                          pin_in.mgmt_addr_strap_bit0};
      nxt_cfg.mode     = {pin_in.mode_strap_bit2, pin_in.mode_strap_bit1,
                          pin_in.mode_strap_bit0};
      nxt_cfg.nand_n   = pin_in.nand_tree_strap_n;
      nxt_cfg.filt_dis = pin_in.line_filter_disable_strap;
    end
  end

  // ------------------------------------------------------------
  // Control register bit 12
  // ------------------------------------------------------------
  assign ctrl_wr = reg_wr && (reg_addr == psl_strap_pkg::PSL_CTRL_ADDR) &&
                   (state_ff == psl_strap_pkg::PSL_ST_RUN);

  // Strap loads the enable bit at release, software owns it afterwards
  always_comb begin
    nxt_an_ctrl = an_ctrl_ff;
    if (capture) begin
      nxt_an_ctrl = !pin_in.disable_strap_a;
    end else if (ctrl_wr) begin
      nxt_an_ctrl = reg_wdata[psl_strap_pkg::PSL_CTRL_AN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff   <= psl_strap_pkg::PSL_ST_RESET;
      cfg_ff     <= psl_strap_pkg::PSL_CFG_RST;
      an_ctrl_ff <= !psl_strap_pkg::PSL_AN_DIS_RST;
    end else begin
      state_ff   <= nxt_state;
      cfg_ff     <= nxt_cfg;
      an_ctrl_ff <= nxt_an_ctrl;
    end
  end

  // ------------------------------------------------------------
  // Shared pin drivers
  // ------------------------------------------------------------
  // Pins float on their weak pulls while reset is low, then drive the normal function
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_oe_n_ff <= psl_strap_pkg::PSL_PINS_OFF;
      pin_out_ff  <= 9'h000;
    end else begin
      pin_oe_n_ff <= chip_reset_n ? 9'h000 : psl_strap_pkg::PSL_PINS_OFF;
      pin_out_ff  <= fn_out;
    end
  end

  assign pin_out  = pin_out_ff;
  assign pin_oe_n = pin_oe_n_ff;

  // ------------------------------------------------------------
  // Register read path
  // ------------------------------------------------------------
  assign ctrl_word  = an_ctrl_ff ? psl_strap_pkg::PSL_CTRL_MASK : 16'h0000;
  assign strap_word = {6'h00, cfg_ff.filt_dis, cfg_ff.nand_n, cfg_ff.mode, mgmt_addr};

  // Unmapped addresses read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd && reg_addr == psl_strap_pkg::PSL_CTRL_ADDR) begin
      nxt_rdata = ctrl_word;
    end else if (reg_rd && reg_addr == psl_strap_pkg::PSL_STRAP_ADDR) begin
      nxt_rdata = strap_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  assign mgmt_addr      = {2'h0, cfg_ff.addr};
  assign mode_code      = cfg_ff.mode;
  assign mode_xover_en  = mode_xover(cfg_ff.mode);
  assign mode_b2b       = (cfg_ff.mode == psl_strap_pkg::PSL_MODE_B2B);
  assign mode_reserved  = mode_rsvd(cfg_ff.mode);
  assign disable_strap_a_en     = an_ctrl_ff;
  assign nand_tree_en   = !cfg_ff.nand_n;
  assign line_filter_en = !cfg_ff.filt_dis;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_release;
    !chip_reset_n ##1 chip_reset_n;
  endsequence

  sequence s_held_run;
    (!rst && chip_reset_n) ##1 chip_reset_n;
  endsequence

  property p_addr_capture;
    @(posedge core_clk) disable iff (rst)
      capture |=> mgmt_addr[2:0] == {$past(pin_in.mgmt_addr_strap_bit2),
                  $past(pin_in.mgmt_addr_strap_bit1), $past(pin_in.mgmt_addr_strap_bit0)};
  endproperty
  a_addr_capture: assert property (p_addr_capture)
    else $error("Address strap not captured");

  property p_addr_default;
    @(posedge core_clk) rst |=> mgmt_addr == psl_strap_pkg::PSL_ADDR_RST;
  endproperty
  a_addr_default: assert property (p_addr_default)
    else $error("Default address is not 00001");

  property p_addr_upper;
    @(posedge core_clk) disable iff (rst) mgmt_addr[4:3] == 2'h0;
  endproperty
  a_addr_upper: assert property (p_addr_upper)
    else $error("Upper address bits not zero");

  property p_mode_decode;
    @(posedge core_clk) disable iff (rst)
      capture |=> mode_xover_en == ($past(pin_in.mode_strap_bit2) && $past(pin_in.mode_strap_bit0))
                  && mode_b2b == ($past(pin_in.mode_strap_bit2) && !$past(pin_in.mode_strap_bit1)
                  && $past(pin_in.mode_strap_bit0));
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("Mode code decoded wrongly");

  property p_an_strap;
    @(posedge core_clk) disable iff (rst)
      capture |=> ctrl_word[12] == !$past(pin_in.disable_strap_a);
  endproperty
  a_an_strap: assert property (p_an_strap)
    else $error("Auto-negotiation strap not in control bit 12");

  property p_an_level;
    @(posedge core_clk) disable iff (rst)
      capture && pin_in.disable_strap_a |=> !disable_strap_a_en;
  endproperty
  a_an_level: assert property (p_an_level)
    else $error("High strap did not disable auto-negotiation");

  property p_nand;
    @(posedge core_clk) disable iff (rst)
      capture |=> nand_tree_en == !$past(pin_in.nand_tree_strap_n);
  endproperty
  a_nand: assert property (p_nand)
    else $error("NAND-tree strap wrong");

  property p_filter;
    @(posedge core_clk) disable iff (rst)
      capture |=> line_filter_en == !$past(pin_in.line_filter_disable_strap);
  endproperty
  a_filter: assert property (p_filter)
    else $error("Filter strap wrong");

  property p_pins;
    @(posedge core_clk) disable iff (rst)
      (!chip_reset_n |=> pin_oe_n == 9'h1FF) and (s_held_run |-> pin_oe_n == 9'h000);
  endproperty
  a_pins: assert property (p_pins)
    else $error("Strap pin direction wrong");

  property p_sw_write;
    @(posedge core_clk) disable iff (rst)
      ctrl_wr && !capture |=> disable_strap_a_en == $past(reg_wdata[psl_strap_pkg::PSL_CTRL_AN_BIT]);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("Software write to bit 12 lost");

  property p_release;
    @(posedge core_clk) disable iff (rst)
      s_release |=> state_ff == psl_strap_pkg::PSL_ST_RUN;
  endproperty
  a_release: assert property (p_release)
    else $error("Release not seen");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
      !capture |=> cfg_ff == $past(cfg_ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Captured straps changed");

  property p_an_low;
    @(posedge core_clk) disable iff (rst)
      capture && !pin_in.disable_strap_a |=> disable_strap_a_en;
  endproperty
  a_an_low: assert property (p_an_low)
    else $error("Low strap did not enable auto-negotiation");

  property p_mode_rsvd;
    @(posedge core_clk) disable iff (rst)
      mode_reserved == !(mode_code[0] && (mode_code[2] || !mode_code[1]));
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd)
    else $error("Reserved mode flag wrong");

  property p_pin_func;
    @(posedge core_clk) disable iff (rst)
      !rst |=> pin_out == $past(fn_out);
  endproperty
  a_pin_func: assert property (p_pin_func)
    else $error("Pin does not carry its normal function");

  property p_strap_read;
    @(posedge core_clk) disable iff (rst)
      reg_rd && reg_addr == psl_strap_pkg::PSL_STRAP_ADDR |=>
        reg_rdata[4:0] == $past(mgmt_addr);
  endproperty
  a_strap_read: assert property (p_strap_read)
    else $error("Strap word address field wrong");

  property p_ctrl_read;
    @(posedge core_clk) disable iff (rst)
      reg_rd && reg_addr == psl_strap_pkg::PSL_CTRL_ADDR |=>
        reg_rdata == ($past(disable_strap_a_en) ? psl_strap_pkg::PSL_CTRL_MASK : 16'h0000);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("Control bit 12 reads wrong");

  property p_an_keep;
    @(posedge core_clk) disable iff (rst)
      !capture && !ctrl_wr |=> disable_strap_a_en == $past(disable_strap_a_en);
  endproperty
  a_an_keep: assert property (p_an_keep)
    else $error("Auto-negotiation bit changed on its own");

endmodule

//--- psl_strap_pkg.sv
// Operation
// - At reset release three strap pins are captured as management address bits 2 to 0, any value 0 to 7.
// - With every address strap at its pull default the management address reads 00001.
// - Management address bits 4 and 3 cannot be strapped and always read zero.
// - A 3-bit mode code is captured at release: 001 normal without crossover, 101 back-to-back with crossover, 111 normal with crossover, the rest reserved.
// - The auto-negotiation strap is captured at release inverted into bit 12 of control register 0h.
// - A high auto-negotiation strap (the pulled-up default) disables auto-negotiation and a low one enables it.
// - A high NAND-tree strap (the default) keeps normal operation and a low one enables NAND-tree test mode.
// - A high line-filter strap disables the emission filter and a low one (the default) enables it.
// - Every strap pin is an input with a weak pull during reset and takes up its output function after release.
// - After reset, software writes to bit 12 of control register 0h override the strapped auto-negotiation setting.
// - The chip reset pin is active low and straps are captured on its low-to-high transition.
package psl_strap_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [4:0]  PSL_CTRL_ADDR   = 5'h00;
  localparam logic [4:0]  PSL_STRAP_ADDR  = 5'h10;
  localparam int          PSL_CTRL_AN_BIT = 12;
  localparam logic [15:0] PSL_CTRL_MASK   = 16'h1000;

  // ------------------------------------------------------------
  // Strap defaults and mode codes
  // ------------------------------------------------------------
  localparam logic [4:0] PSL_ADDR_RST  = 5'h01;
  localparam logic [2:0] PSL_MODE_RST  = 3'h1;
  localparam logic [2:0] PSL_MODE_NRM  = 3'h1;
  localparam logic [2:0] PSL_MODE_B2B  = 3'h5;
  localparam logic [2:0] PSL_MODE_NRMX = 3'h7;
  localparam logic       PSL_AN_DIS_RST = 1'h1;
  localparam logic       PSL_NAND_RST   = 1'h1;
  localparam logic       PSL_FILT_RST   = 1'h0;

  // Shared strap pins, one bit each
  typedef struct packed {
    logic mgmt_addr_strap_bit2;
    logic mgmt_addr_strap_bit1;
    logic mgmt_addr_strap_bit0;
    logic mode_strap_bit2;
    logic mode_strap_bit1;
    logic mode_strap_bit0;
    logic disable_strap_a;
    logic nand_tree_strap_n;
    logic line_filter_disable_strap;
  } psl_pins_t;

  localparam logic [8:0] PSL_PINS_OFF = 9'h1FF;

  // Captured configuration
  typedef struct packed {
    logic [2:0] addr;
    logic [2:0] mode;
    logic       nand_n;
    logic       filt_dis;
  } psl_cfg_t;

  localparam psl_cfg_t PSL_CFG_RST = '{addr:     PSL_ADDR_RST[2:0],
                                       mode:     PSL_MODE_RST,
                                       nand_n:   PSL_NAND_RST,
                                       filt_dis: PSL_FILT_RST};

  typedef enum logic [1:0] {
    PSL_ST_RESET = 2'h1,
    PSL_ST_RUN   = 2'h2
  } psl_state_t;

endpackage

//--- tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb;
  logic                      core_clk, rst, chip_reset_n, reg_wr, reg_rd;
  logic [4:0]                reg_addr, mgmt_addr;
  logic [15:0]               reg_wdata, reg_rdata, rdv;
  logic [8:0]                pin_out, pin_oe_n, ext_en, ext_val;
  logic [2:0]                mode_code;
  logic                      mode_b2b, mode_xover_en, mode_reserved;
  logic                      disable_strap_a_en, nand_tree_en, line_filter_en;
  psl_strap_pkg::psl_pins_t  pin_in, fn_out;
  int                        n_fail, cmp_count, cyc;

  psl_strap_latch dut (.core_clk(core_clk), .rst(rst), .chip_reset_n(chip_reset_n),
    .pin_in(pin_in), .fn_out(fn_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mgmt_addr(mgmt_addr), .mode_code(mode_code),
    .mode_b2b(mode_b2b), .mode_xover_en(mode_xover_en), .mode_reserved(mode_reserved),
    .disable_strap_a_en(disable_strap_a_en), .nand_tree_en(nand_tree_en), .line_filter_en(line_filter_en));

  psl_board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // ------------------------------------------------------------
  // Clock, inputs at time zero, cycle limit
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Register port and strap capture tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk) begin reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d; end
    @(posedge core_clk) reg_wr <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge core_clk) begin reg_rd <= 1'h1; reg_addr <= a; end
    @(posedge core_clk) reg_rd <= 1'h0;
    #1 rdv = reg_rdata;
  endtask

  // Hold chip reset low with given board straps, then release
  task automatic cap(input logic [8:0] en, input logic [8:0] v);
    @(posedge core_clk) begin ext_en <= en; ext_val <= v; chip_reset_n <= 1'h0; end
    repeat (3) @(posedge core_clk);
    #1 `CHK("oe_n in reset", 9'h1FF, pin_oe_n)
    @(posedge core_clk) chip_reset_n <= 1'h1;
    @(posedge core_clk);
    #1 `CHK("oe_n after release", 9'h000, pin_oe_n)
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_default();
    cap(9'h000, 9'h000);
    `CHK("addr", 5'h01, mgmt_addr)
    `CHK("mode", 3'h0, mode_code)
    `CHK("reserved", 1'h1, mode_reserved)
    `CHK("an", 1'h0, disable_strap_a_en)
    `CHK("nand", 1'h0, nand_tree_en)
    `CHK("filt", 1'h1, line_filter_en)
    rd(5'h10);
    `CHK("strap word", 16'h0101, rdv)
    $display("test default done");
  endtask

  task automatic t_sweep();
    logic [2:0] a, m;
    logic       an, nd, ft;
    for (int i = 0; i < 8; i++) begin
      a = 3'(i);
      m = 3'(7 - i);
      {an, nd, ft} = 3'(i);
      cap(9'h1FF, {a, m, an, nd, ft});
      `CHK("addr", {2'h0, a}, mgmt_addr)
      `CHK("mode", m, mode_code)
      `CHK("b2b", m == 3'h5, mode_b2b)
      `CHK("xover", m == 3'h5 || m == 3'h7, mode_xover_en)
      `CHK("reserved", !(m == 3'h1 || m == 3'h5 || m == 3'h7), mode_reserved)
      `CHK("an", ~an, disable_strap_a_en)
      `CHK("nand", ~nd, nand_tree_en)
      `CHK("filt", ~ft, line_filter_en)
      rd(5'h00);
      `CHK("ctrl", an ? 16'h0000 : 16'h1000, rdv)
      rd(5'h10);
      `CHK("strap word", {6'h00, ft, nd, m, 2'h0, a}, rdv)
    end
    $display("test sweep done");
  endtask

  task automatic t_hold();
    cap(9'h1FF, 9'h1C0);
    @(posedge core_clk) begin ext_val <= 9'h03F; fn_out <= 9'h0A5; end
    repeat (2) @(posedge core_clk);
    #1 `CHK("pin_out", 9'h0A5, pin_out)
    `CHK("pin_in", 9'h0A5, pin_in)
    `CHK("addr held", 5'h07, mgmt_addr)
    `CHK("mode held", 3'h0, mode_code)
    `CHK("an held", 1'h1, disable_strap_a_en)
    $display("test hold done");
  endtask

  task automatic t_regs();
    cap(9'h000, 9'h000);
    wr(5'h00, 16'h1000);
    `CHK("an set", 1'h1, disable_strap_a_en)
    wr(5'h00, 16'hEFFF);
    `CHK("an clear", 1'h0, disable_strap_a_en)
    wr(5'h00, 16'hFFFF);
    rd(5'h00);
    `CHK("ctrl", 16'h1000, rdv)
    wr(5'h10, 16'hFFFF);
    rd(5'h10);
    `CHK("strap ro", 16'h0101, rdv)
    rd(5'h03);
    `CHK("unmapped", 16'h0000, rdv)
    $display("test regs done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'h1;
    chip_reset_n = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    ext_en = 9'h000;
    ext_val = 9'h000;
    fn_out = 9'h000;
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    t_default();
    t_sweep();
    t_hold();
    t_regs();
    wrap_up();
  end
endmodule
